// *** sdii_pkg.sv ***
// Constants and types for the serial DAC input interface.
// What this block does
// R01: Shift serial input on framed clock falls.
// R02: Host sends one 16-bit word per update.
// R03: Frame low restarts shift logic and counter.
// R04: Strobed mode loads latch on strobe fall.
// R05: Strobe low gives load on 16th fall.
// R06: Chain select picks standalone or chain shifting.
// R07: Chain mode drives serial out each fall.
// R08: Clear forces zero code, per coding output.
// R09: Unipolar ranges use natural binary at 0.
// R10: Bipolar: 0 offset binary, 1 two's complement.
// R11: First four bits ignored, low twelve latched.
// R12: Standalone counter locks out edges past 16.
// R13: Strobe level at frame fall picks mode.
// R14: Clear loads zeros straight into latch.
// R15: Two's complement inverts data MSB.
package sdii_pkg;

    localparam int WORD_BITS = 16;
    localparam int DATA_BITS = 12;
    localparam int CNT_BITS  = 5;
    localparam logic [CNT_BITS-1:0] CNT_FULL = 5'h10;
    localparam logic [CNT_BITS-1:0] CNT_LAST = 5'h0F;
    localparam logic [DATA_BITS-1:0] DATA_MSB_MASK = 12'h800;
    localparam logic [DATA_BITS-1:0] LATCH_RST = 12'h000;

    // Register offsets, byte addresses
    localparam logic [7:0] ADR_CTRL   = 8'h00;
    localparam logic [7:0] ADR_STATUS = 8'h04;
    localparam logic [7:0] ADR_CODE   = 8'h08;

    // Field positions
    localparam int CTRL_SOFT_CLEAR = 0;
    localparam int STAT_AUTO       = 16;
    localparam int STAT_CHAIN      = 17;
    localparam int STAT_CNT_LO     = 18;
    localparam int STAT_FRAME      = 23;
    localparam logic CTRL_RST      = 1'b0;

    // Pin group that crosses into the clock domain
    typedef struct packed {
        logic frame_n;
        logic sclk;
        logic serial_in;
        logic latch_load_n;
        logic chain_mode_select;
        logic output_zero_n;
        logic coding_select;
        logic range_bipolar;
    } sdii_pins_t;

    localparam sdii_pins_t PINS_IDLE = 8'hD4;

endpackage : sdii_pkg

// *** sdii_sync.sv ***
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/10ps
module sdii_sync
    import sdii_pkg::*;
#(
    parameter int             W   = 8,
    parameter logic [W-1:0]   RST = '0
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] stable_o
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] agree;
    logic [W-1:0] stable_d;

    // Bit follows only when stages two and three agree
    assign agree    = ~(s2_q ^ s3_q);
    assign stable_d = (agree & s3_q) | (~agree & stable_o);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_q     <= RST;
            s2_q     <= RST;
            s3_q     <= RST;
            stable_o <= RST;
        end else begin
            s1_q     <= async_i;
            s2_q     <= s1_q;
            s3_q     <= s2_q;
            stable_o <= stable_d;
        end
    end

endmodule : sdii_sync

// *** sdii_top.sv ***
// Serial DAC input shift logic, DAC latch and register slave.
//
// Local design decisions: the register addresses and the Wishbone slave port.
`timescale 1ns/10ps
module sdii_top
    import sdii_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // Serial pins
    input  wire logic                 frame_n_i,
    input  wire logic                 sclk_i,
    input  wire logic                 serial_in_i,
    input  wire logic                 latch_load_n_i,
    input  wire logic                 chain_mode_select_i,
    input  wire logic                 output_zero_n_i,
    input  wire logic                 coding_select_i,
    input  wire logic                 range_bipolar_i,
    output logic                      serial_out_o,
    output logic                      serial_out_en_o,
    // Converter side
    output logic [DATA_BITS-1:0]      dac_latch_o,
    output logic [DATA_BITS-1:0]      dac_code_o,
    // Wishbone classic slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic [31:0]               wb_dat_o,
    output logic                      wb_ack_o
);

    // ------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------
    sdii_pins_t pins_raw;
    sdii_pins_t pins;
    sdii_pins_t pins_prev_q;

    assign pins_raw.frame_n           = frame_n_i;
    assign pins_raw.sclk              = sclk_i;
    assign pins_raw.serial_in         = serial_in_i;
    assign pins_raw.latch_load_n      = latch_load_n_i;
    assign pins_raw.chain_mode_select = chain_mode_select_i;
    assign pins_raw.output_zero_n     = output_zero_n_i;
    assign pins_raw.coding_select     = coding_select_i;
    assign pins_raw.range_bipolar     = range_bipolar_i;

    sdii_sync #(
        .W   ($bits(sdii_pins_t)),
        .RST (PINS_IDLE)
    ) u_sync (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .async_i  (pins_raw),
        .stable_o (pins)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pins_prev_q <= PINS_IDLE;
        end else begin
            pins_prev_q <= pins;
        end
    end

    // ------------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------------
    logic frame_fall;
    logic frame_active;
    logic sclk_fall;
    logic load_fall;

    assign frame_fall   = pins_prev_q.frame_n & ~pins.frame_n;
    assign frame_active = ~pins.frame_n;
    assign sclk_fall    = pins_prev_q.sclk & ~pins.sclk;
    assign load_fall    = pins_prev_q.latch_load_n & ~pins.latch_load_n;

    // ------------------------------------------------------------------
    // Input shift register and bit counter
    // ------------------------------------------------------------------
    logic [WORD_BITS-1:0] shift_q;
    logic [WORD_BITS-1:0] shift_d;
    logic [CNT_BITS-1:0]  cnt_q;
    logic [CNT_BITS-1:0]  cnt_d;
    logic                 auto_q;
    logic                 auto_d;
    logic                 gate_open;
    logic                 shift_en;
    logic                 last_bit;
    logic                 chain_mode;

    assign chain_mode = pins.chain_mode_select;                // [R06]
    // Standalone gating closes after a full word
    assign gate_open  = chain_mode | (cnt_q != CNT_FULL);      // [R12]
    // Frame fall cycle restarts, so no shift on it
    assign shift_en   = frame_active & ~frame_fall & sclk_fall
                        & gate_open;                           // [R01]
    assign last_bit   = shift_en & (cnt_q == CNT_LAST);
    assign shift_d    = shift_en
                        ? {shift_q[WORD_BITS-2:0], pins.serial_in}
                        : shift_q;                             // [R01]

    always_comb begin
        cnt_d  = cnt_q;
        auto_d = auto_q;
        if (frame_fall) begin
            cnt_d  = '0;                                       // [R03]
            auto_d = ~pins.latch_load_n;                       // [R13]
        end else if (shift_en && cnt_q != CNT_FULL) begin
            cnt_d  = cnt_q + 5'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shift_q <= '0;
            cnt_q   <= CNT_FULL;
            auto_q  <= 1'b0;
        end else begin
            shift_q <= shift_d;
            cnt_q   <= cnt_d;
            auto_q  <= auto_d;
        end
    end

    // ------------------------------------------------------------------
    // Serial output for daisy chaining
    // ------------------------------------------------------------------
    logic serial_out_d;

    assign serial_out_d = (chain_mode && shift_en) ? shift_q[WORD_BITS-1]
                        : (chain_mode ? serial_out_o : 1'b0);   // [R07]

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            serial_out_o    <= 1'b0;
            serial_out_en_o <= 1'b0;
        end else begin
            serial_out_o    <= serial_out_d;
            serial_out_en_o <= chain_mode;                     // [R07]
        end
    end

    // ------------------------------------------------------------------
    // DAC latch
    // ------------------------------------------------------------------
    logic                 soft_clear_q;
    logic                 clear_act;
    logic                 auto_load;
    logic                 strobe_load;
    logic [DATA_BITS-1:0] word_now;
    logic [DATA_BITS-1:0] latch_d;

    assign clear_act   = ~pins.output_zero_n | soft_clear_q;
    assign auto_load   = auto_q & last_bit;                    // [R05]
    assign strobe_load = ~auto_q & load_fall;                  // [R04]
    // Low twelve bits of the word, newest bit last
    assign word_now    = shift_d[DATA_BITS-1:0];               // [R11]

    always_comb begin
        latch_d = dac_latch_o;
        if (clear_act) begin
            latch_d = LATCH_RST;                               // [R14] [R08]
        end else if (auto_load || strobe_load) begin
            latch_d = word_now;                                // [R04] [R05]
        end
    end

    // ------------------------------------------------------------------
    // Code format
    // ------------------------------------------------------------------
    logic                 twos_comp;
    logic [DATA_BITS-1:0] code_d;

    // Unipolar: natural binary; bipolar: pin picks coding
    assign twos_comp = pins.range_bipolar & pins.coding_select; // [R09] [R10]
    assign code_d    = twos_comp ? (latch_d ^ DATA_MSB_MASK)
                                 : latch_d;                     // [R15] [R08]

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dac_latch_o <= LATCH_RST;
            dac_code_o  <= LATCH_RST;
        end else begin
            dac_latch_o <= latch_d;
            dac_code_o  <= code_d;
        end
    end

    // ------------------------------------------------------------------
    // Wishbone register slave
    // ------------------------------------------------------------------
    logic        wb_req;
    logic        wb_wr_ctrl;
    logic        hit_ctrl;
    logic        hit_status;
    logic        hit_code;
    logic [31:0] status_word;
    logic [31:0] rd_data;

    assign wb_req     = wb_cyc_i & wb_stb_i;
    assign hit_ctrl   = wb_adr_i == ADR_CTRL;
    assign hit_status = wb_adr_i == ADR_STATUS;
    assign hit_code   = wb_adr_i == ADR_CODE;
    // Write lands on the edge where the master sees ack
    assign wb_wr_ctrl = wb_req & wb_ack_o & wb_we_i & hit_ctrl
                        & wb_sel_i[0];

    always_comb begin
        status_word = '0;
        status_word[DATA_BITS-1:0]                  = dac_latch_o;
        status_word[STAT_AUTO]                      = auto_q;
        status_word[STAT_CHAIN]                     = chain_mode;
        status_word[STAT_CNT_LO+CNT_BITS-1:STAT_CNT_LO] = cnt_q;
        status_word[STAT_FRAME]                     = frame_active;
    end

    // Unmapped addresses answer with zero
    assign rd_data = hit_ctrl   ? {31'h00000000, soft_clear_q}
                   : hit_status ? status_word
                   : hit_code   ? {20'h00000, dac_code_o}
                   : 32'h00000000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o     <= 1'b0;
            wb_dat_o     <= '0;
            soft_clear_q <= CTRL_RST;
        end else begin
            wb_ack_o <= wb_req & ~wb_ack_o;
            wb_dat_o <= (wb_req & ~wb_ack_o & ~wb_we_i) ? rd_data
                                                        : 32'h00000000;
            if (wb_wr_ctrl) begin
                soft_clear_q <= wb_dat_i[CTRL_SOFT_CLEAR];
            end
        end
    end

endmodule : sdii_top

// *** sdii_properties.sv ***
// Port checks for the serial DAC input interface.
`timescale 1ns/10ps
module sdii_properties
    import sdii_pkg::*;
(
    input logic                 clk_i,
    input logic                 rst_i,
    input logic                 chain_mode_select_i,
    input logic                 output_zero_n_i,
    input logic                 coding_select_i,
    input logic                 range_bipolar_i,
    input logic                 serial_out_o,
    input logic                 serial_out_en_o,
    input logic [DATA_BITS-1:0] dac_latch_o,
    input logic [DATA_BITS-1:0] dac_code_o,
    input logic                 wb_cyc_i,
    input logic                 wb_stb_i,
    input logic [31:0]          wb_dat_o,
    input logic                 wb_ack_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence clr_held;
        (!output_zero_n_i)[*8];
    endsequence
    sequence twos_held;
        (range_bipolar_i && coding_select_i && $stable(dac_latch_o))[*8];
    endsequence
    sequence plain_held;
        (!(range_bipolar_i && coding_select_i) && $stable(dac_latch_o))[*8];
    endsequence
    ack_timing_a: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    read_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data outside ack");
    clear_zero_a: assert property (
        clr_held |-> dac_latch_o == LATCH_RST)
        else $error("latch not cleared");
    twos_code_a: assert property (
        twos_held |-> dac_code_o == (dac_latch_o ^ DATA_MSB_MASK))
        else $error("code msb not inverted");
    plain_code_a: assert property (
        plain_held |-> dac_code_o == dac_latch_o)
        else $error("code differs from latch");
    chain_off_a: assert property (
        (!chain_mode_select_i)[*8] |-> !serial_out_en_o && !serial_out_o)
        else $error("serial out active standalone");
    chain_on_a: assert property (
        chain_mode_select_i[*8] |-> serial_out_en_o)
        else $error("serial out not enabled");
endmodule : sdii_properties
bind sdii_top sdii_properties sdii_properties_inst (.*);

// *** sdii_host.sv ***
// Host serial port model: frame, serial clock, data.
`timescale 1ns/10ps
module sdii_host (
    output logic frame_n_o,
    output logic sclk_o,
    output logic sdata_o
);
    initial begin
        frame_n_o = 1'b1;
        sclk_o    = 1'b1;
        sdata_o   = 1'b0;
    end
    task automatic open_frame();
        #37 frame_n_o = 1'b0;
        #40;
    endtask : open_frame
    // Clock idles high outside frames
    task automatic shift_word(input logic [15:0] w);
        for (int i = 15; i >= 0; i--) begin
            sdata_o = w[i];
            #40 sclk_o = 1'b0;
            #40 sclk_o = 1'b1;
        end
    endtask : shift_word
    task automatic close_frame();
        #40 frame_n_o = 1'b1;
        sdata_o = ~sdata_o;
    endtask : close_frame
endmodule : sdii_host

// *** sdii_top_tb.sv ***
// Self-checking bench for the serial DAC input interface.
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
    $display("BAD %0t got %h exp %h", $time, a, b); end end
module sdii_top_tb
    import sdii_pkg::*;
;
    logic                 clk_i, rst_i, frame_n, sclk, sdata, load_n;
    logic                 chain, zero_n, coding, bipolar, sout, sout_en;
    logic                 cyc, stb, we, ack;
    logic [7:0]           adr;
    logic [31:0]          wdat, rdat, q;
    logic [3:0]           sel, wsel;
    logic [DATA_BITS-1:0] latch, code;
    int                   n_errors = 0;
    int                   tests_run = 0;

    sdii_host sdii_host_inst (.frame_n_o(frame_n), .sclk_o(sclk),
        .sdata_o(sdata));
    sdii_top sdii_top_inst (.clk_i(clk_i), .rst_i(rst_i),
        .frame_n_i(frame_n), .sclk_i(sclk), .serial_in_i(sdata),
        .latch_load_n_i(load_n), .chain_mode_select_i(chain),
        .output_zero_n_i(zero_n), .coding_select_i(coding),
        .range_bipolar_i(bipolar), .serial_out_o(sout),
        .serial_out_en_o(sout_en), .dac_latch_o(latch), .dac_code_o(code),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // --------------------------------
    // Tasks
    // --------------------------------
    task automatic results();
        $display("Checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int i;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= wsel;
        adr <= a;
        wdat <= d;
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (ack !== 1'b1 && i < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            n_errors++;
            results();
        end
        @(posedge clk_i);
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask : rd
    task automatic frame16(input logic [15:0] w);
        sdii_host_inst.open_frame();
        sdii_host_inst.shift_word(w);
        sdii_host_inst.close_frame();
        tick(10);
    endtask : frame16
    task automatic load_pulse();
        load_n <= 1'b0;
        tick(6);
        load_n <= 1'b1;
        tick(10);
    endtask : load_pulse
    // --------------------------------
    // Sequence
    // --------------------------------
    initial begin
        {rst_i, load_n, zero_n} = 3'h7;
        {chain, coding, bipolar, cyc, stb, we} = 6'h00;
        adr = 8'h00;
        sel = 4'hF;
        wsel = 4'hF;
        wdat = 32'h0;
        tick(20);
        rst_i <= 1'b0;
        rd(ADR_CTRL, 32'h0);
        wb(1'b1, 8'h0C, 32'hFFFFFFFF);
        wb(1'b1, ADR_CODE, 32'h00000FFF);
        rd(8'h0C, 32'h0);
        rd(ADR_CODE, 32'h0);
        load_n <= 1'b0;
        tick(6);
        frame16(16'hA5C3);
        `CHK(latch, 12'h5C3)
        `CHK(code, 12'h5C3)
        load_n <= 1'b1;
        tick(6);
        sdii_host_inst.open_frame();
        sdii_host_inst.shift_word(16'hF789);
        sdii_host_inst.shift_word(16'h0ABC);
        sdii_host_inst.close_frame();
        tick(10);
        `CHK(latch, 12'h5C3)
        load_pulse();
        `CHK(latch, 12'h789)
        rd(ADR_STATUS, 32'h00400789);
        bipolar <= 1'b1;
        coding <= 1'b1;
        tick(10);
        rd(ADR_CODE, 32'h00000F89);
        coding <= 1'b0;
        tick(10);
        `CHK(code, 12'h789)
        wb(1'b1, ADR_CTRL, 32'h1);
        tick(8);
        `CHK(latch, 12'h000)
        rd(ADR_CTRL, 32'h1);
        wsel = 4'hE;
        wb(1'b1, ADR_CTRL, 32'h0);
        wsel = 4'hF;
        rd(ADR_CTRL, 32'h1);
        wb(1'b1, ADR_CTRL, 32'h0);
        zero_n <= 1'b0;
        coding <= 1'b1;
        load_n <= 1'b0;
        tick(6);
        frame16(16'h0FFF);
        `CHK(latch, 12'h000)
        `CHK(code, 12'h800)
        coding <= 1'b0;
        tick(10);
        `CHK(code, 12'h000)
        {zero_n, chain, load_n, bipolar} <= 4'hE;
        tick(10);
        sdii_host_inst.open_frame();
        sdii_host_inst.shift_word(16'h0001);
        sdii_host_inst.shift_word(16'h0DEF);
        sdii_host_inst.close_frame();
        tick(10);
        `CHK({sout_en, sout}, 2'h3)
        load_pulse();
        `CHK(latch, 12'hDEF)
        results();
    end
endmodule : sdii_top_tb
